/* File: hdl/alb_consts.svh */
// register offsets, field positions, reset values and timing counts
`ifndef ALB_CONSTS_SVH
`define ALB_CONSTS_SVH
`define ALB_OFS_GAIN 8'h08
`define ALB_OFS_FLOOR 8'h09
`define ALB_OFS_TIM 8'h0A
`define ALB_MASK_GAIN 8'h9F
`define ALB_MASK_FLOOR 8'h0F
`define ALB_MASK_TIM 8'h3F
`define ALB_RST_VAL 8'h00
`define ALB_BIAS_BIT 7
`define ALB_GAIN_MSB 4
`define ALB_FLOOR_MSB 3
`define ALB_TIM_MSB 5
`define ALB_SENSE_SHIFT 2
`define ALB_STEP_BASE_MS 50
`define ALB_CLK_MHZ 250
`define ALB_STEP_BASE_CYC (`ALB_STEP_BASE_MS * `ALB_CLK_MHZ * 1000)
`endif

/* File: hdl/alb_pkg.sv */
// types shared by the ambient brightness block
package alb_pkg;
  typedef enum logic [1:0] {RS_SHUT, RS_IDLE, RS_PAUSE, RS_TRACK} alb_reg_state_type;
  typedef enum logic [1:0] {SEQ_SYNC, SEQ_STAGGER, SEQ_INDEP, SEQ_FREE} alb_seq_type;
endpackage : alb_pkg

/* File: hdl/alb_cfg_if.sv */
// configuration fields carried from the register file to the core
`timescale 1ns/10ps
`default_nettype none
interface alb_cfg_if;
  logic bias_on;
  logic [4:0] gain;
  logic [3:0] floor_lvl;
  logic [5:0] step_sel;
  modport regs (output bias_on, gain, floor_lvl, step_sel);
  modport core (input bias_on, gain, floor_lvl, step_sel);
endinterface : alb_cfg_if
`default_nettype wire

/* File: hdl/alb_regs.sv */
// register file for bias/gain, floor level and step timing
`timescale 1ns/10ps
`default_nettype none
`include "alb_consts.svh"
module alb_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // configuration out
  alb_cfg_if.regs cfg
);
  logic [7:0] gain_reg;
  logic [7:0] floor_reg;
  logic [7:0] tim_reg;
  logic [7:0] rdata_reg;
  wire sel_gain = addr == `ALB_OFS_GAIN;
  wire sel_floor = addr == `ALB_OFS_FLOOR;
  wire sel_tim = addr == `ALB_OFS_TIM;
  // unmapped addresses read as zero
  wire [7:0] rd_mux = sel_gain ? gain_reg : sel_floor ? floor_reg :
    sel_tim ? tim_reg : 8'h00;
  always_ff @(posedge clk) begin
    if (rst) begin
      gain_reg <= `ALB_RST_VAL;
      floor_reg <= `ALB_RST_VAL;
      tim_reg <= `ALB_RST_VAL;
      rdata_reg <= 8'h00;
    end else if (ce) begin
      // reserved bits are dropped at write so they read zero
      if (wr && sel_gain) gain_reg <= wdata & `ALB_MASK_GAIN;
      if (wr && sel_floor) floor_reg <= wdata & `ALB_MASK_FLOOR;
      if (wr && sel_tim) tim_reg <= wdata & `ALB_MASK_TIM;
      if (rd) rdata_reg <= rd_mux;
    end
  end
  assign rdata = rdata_reg;
  assign cfg.bias_on = gain_reg[`ALB_BIAS_BIT];
  assign cfg.gain = gain_reg[`ALB_GAIN_MSB:0];
  assign cfg.floor_lvl = floor_reg[`ALB_FLOOR_MSB:0];
  assign cfg.step_sel = tim_reg[`ALB_TIM_MSB:0];
endmodule : alb_regs
`default_nettype wire

/* File: hdl/alb_pwm_chan.sv */
// one keyboard pwm channel with a shared ramp for rise and fall
`timescale 1ns/10ps
`default_nettype none
module alb_pwm_chan (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // timing
  input wire logic [4:0] phase,
  input wire logic ramp_tick,
  // control
  input wire logic go,
  input wire logic ramp_on,
  input wire logic [4:0] target,
  // status and pin
  output logic done,
  output logic active,
  output logic pwm
);
  logic [4:0] eff_reg;
  logic [4:0] eff_next;
  logic pwm_reg;
  wire [4:0] goal = go ? target : 5'h00;
  always_comb begin
    eff_next = eff_reg;
    if (!ramp_on) eff_next = goal;
    else if (ramp_tick && eff_reg < goal) eff_next = eff_reg + 5'h01;
    else if (ramp_tick && eff_reg > goal) eff_next = eff_reg - 5'h01;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      eff_reg <= 5'h00;
      pwm_reg <= 1'b0;
    end else if (ce) begin
      eff_reg <= eff_next;
      pwm_reg <= eff_reg > phase;
    end
  end
  assign done = go && eff_reg == target;
  assign active = eff_reg != 5'h00;
  assign pwm = pwm_reg;
endmodule : alb_pwm_chan
`default_nettype wire

/* File: hdl/alb_ambient_ctrl.sv */
// ambient light regulation of the led string and pwm sequencing
`timescale 1ns/10ps
`default_nettype none
`include "alb_consts.svh"
module alb_ambient_ctrl #(
  parameter int STEP_BASE_CYCLES = `ALB_STEP_BASE_CYC
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // serial command activity
  input wire logic bus_cmd_busy,
  // sensor and supply pins
  input wire logic [4:0] ambient_sense_input,
  input wire logic undervoltage_detect,
  // user level and pwm setup
  input wire logic [4:0] max_level,
  input wire logic [1:0] pwm_seq_mode,
  input wire logic [2:0] pwm_chan_en,
  input wire logic [4:0] pwm_duty0,
  input wire logic [4:0] pwm_duty1,
  input wire logic [4:0] pwm_duty2,
  // outputs
  output logic [4:0] led_string_current,
  output logic main_string_en,
  output logic [2:0] pwm_out,
  output logic regulating,
  output logic shutdown
);
  localparam logic [23:0] BASE_LAST = 24'(STEP_BASE_CYCLES - 1);

  // exactly one bit set gives its index, anything else is invalid
  function automatic logic [3:0] onehot_idx(input logic [5:0] s);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 6; i++) begin
      if (s == 6'(1 << i)) r = {1'b1, 3'(i)};
    end
    return r;
  endfunction : onehot_idx

  function automatic logic [4:0] min5(input logic [4:0] a, input logic [4:0] b);
    return (a < b) ? a : b;
  endfunction : min5

  alb_cfg_if cfg ();
  alb_regs u_regs (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .addr(reg_addr),
    .wdata(reg_wdata),
    .wr(reg_wr),
    .rd(reg_rd),
    .rdata(reg_rdata),
    .cfg(cfg)
  );

  // pin synchronisers; stage one is read only by stage two
  logic [4:0] sense_s1_reg;
  logic [4:0] sense_s2_reg;
  logic uv_s1_reg;
  logic uv_s2_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      sense_s1_reg <= 5'h00;
      sense_s2_reg <= 5'h00;
      uv_s1_reg <= 1'b0;
      uv_s2_reg <= 1'b0;
    end else if (ce) begin
      sense_s1_reg <= ambient_sense_input;
      sense_s2_reg <= sense_s1_reg;
      uv_s1_reg <= undervoltage_detect;
      uv_s2_reg <= uv_s1_reg;
    end
  end

  // gain in quarter units, saturated to the 5-bit level scale
  wire [9:0] sense_prod = sense_s2_reg * cfg.gain;
  wire [7:0] sense_scaled = sense_prod[9:`ALB_SENSE_SHIFT];
  wire [4:0] sensed_lvl = (sense_scaled > 8'h1F) ? 5'h1F : sense_scaled[4:0];

  // floor never above maximum: the maximum wins a conflict
  wire [4:0] floor_eff = min5({1'b0, cfg.floor_lvl}, max_level);
  wire [4:0] lvl_target = (sensed_lvl < floor_eff) ? floor_eff :
    min5(sensed_lvl, max_level);

  // regulation state
  alb_pkg::alb_reg_state_type state_reg;
  alb_pkg::alb_reg_state_type state_next;
  wire reg_enable = cfg.bias_on && cfg.gain != 5'h00;
  always_comb begin
    case (1'b1)
      uv_s2_reg: state_next = alb_pkg::RS_SHUT;
      !reg_enable: state_next = alb_pkg::RS_IDLE;
      bus_cmd_busy: state_next = alb_pkg::RS_PAUSE;
      default: state_next = alb_pkg::RS_TRACK;
    endcase
  end
  wire tracking = state_reg == alb_pkg::RS_TRACK;

  // slow base tick shared by level stepping and pwm ramps
  logic [23:0] base_cnt_reg;
  logic base_tick_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      base_cnt_reg <= 24'h000000;
      base_tick_reg <= 1'b0;
    end else if (ce) begin
      base_tick_reg <= base_cnt_reg == BASE_LAST;
      base_cnt_reg <= (base_cnt_reg == BASE_LAST) ? 24'h000000 :
        base_cnt_reg + 24'h000001;
    end
  end

  // step period in base ticks, doubled for downward steps
  logic [4:0] level_reg;
  logic [4:0] level_next;
  logic [6:0] step_cnt_reg;
  logic last_dn_reg;
  wire [3:0] sel_dec = onehot_idx(cfg.step_sel);
  wire sel_ok = sel_dec[3];
  wire dir_up = level_reg < lvl_target;
  wire dir_dn = level_reg > lvl_target;
  wire [6:0] period = dir_dn ? (7'h02 << sel_dec[2:0]) :
    (7'h01 << sel_dec[2:0]);
  wire moving = tracking && sel_ok && (dir_up || dir_dn);
  wire dir_flip = dir_dn != last_dn_reg;
  wire step_fire = moving && !dir_flip && base_tick_reg &&
    step_cnt_reg == period - 7'h01;

  always_ff @(posedge clk) begin
    if (rst) begin
      step_cnt_reg <= 7'h00;
      last_dn_reg <= 1'b0;
    end else if (ce) begin
      last_dn_reg <= dir_dn;
      // a reversal restarts the period so no step is cut short
      if (!moving || dir_flip || step_fire) step_cnt_reg <= 7'h00;
      else if (base_tick_reg) step_cnt_reg <= step_cnt_reg + 7'h01;
    end
  end

  always_comb begin
    level_next = level_reg;
    case (state_reg)
      alb_pkg::RS_SHUT: level_next = 5'h00;
      alb_pkg::RS_IDLE: level_next = max_level;
      alb_pkg::RS_PAUSE: level_next = level_reg;
      alb_pkg::RS_TRACK: begin
        if (level_reg > max_level) level_next = max_level;
        else if (level_reg < floor_eff) level_next = floor_eff;
        else if (step_fire && dir_up) level_next = level_reg + 5'h01;
        else if (step_fire && dir_dn) level_next = level_reg - 5'h01;
      end
      default: level_next = level_reg;
    endcase
  end

  logic main_en_reg;
  logic regulating_reg;
  logic shutdown_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= alb_pkg::RS_IDLE;
      level_reg <= 5'h00;
      main_en_reg <= 1'b0;
      regulating_reg <= 1'b0;
      shutdown_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      level_reg <= level_next;
      main_en_reg <= !uv_s2_reg;
      regulating_reg <= state_next == alb_pkg::RS_TRACK;
      shutdown_reg <= uv_s2_reg;
    end
  end

  // pwm sequencing; channels wait for the main string flop
  logic [4:0] phase_reg;
  always_ff @(posedge clk) begin
    if (rst) phase_reg <= 5'h00;
    else if (ce) phase_reg <= phase_reg + 5'h01;
  end
  alb_pkg::alb_seq_type seq;
  assign seq = alb_pkg::alb_seq_type'(pwm_seq_mode);
  wire [2:0] done;
  wire [2:0] active;
  wire [2:0] raw_pwm;
  wire [2:0] go;
  wire [4:0] tgt [3];
  wire is_sync = seq == alb_pkg::SEQ_SYNC;
  wire power_ok = main_en_reg && !uv_s2_reg;
  // sync mode drives every channel from channel zero's setup
  assign go[0] = power_ok && pwm_chan_en[0];
  assign go[1] = power_ok && (is_sync ? pwm_chan_en[0] : pwm_chan_en[1] &&
    (seq != alb_pkg::SEQ_STAGGER || done[0]));
  assign go[2] = power_ok && (is_sync ? pwm_chan_en[0] : pwm_chan_en[2] &&
    (seq != alb_pkg::SEQ_STAGGER || done[1]));
  assign tgt[0] = pwm_duty0;
  assign tgt[1] = is_sync ? pwm_duty0 : pwm_duty1;
  assign tgt[2] = is_sync ? pwm_duty0 : pwm_duty2;
  wire ramp_on = seq != alb_pkg::SEQ_FREE;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_chan
      alb_pwm_chan u_chan (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .phase(phase_reg),
        .ramp_tick(base_tick_reg),
        .go(go[g]),
        .ramp_on(ramp_on),
        .target(tgt[g]),
        .done(done[g]),
        .active(active[g]),
        .pwm(raw_pwm[g])
      );
    end
  endgenerate

  assign led_string_current = level_reg;
  assign main_string_en = main_en_reg;
  assign pwm_out = raw_pwm;
  assign regulating = regulating_reg;
  assign shutdown = shutdown_reg;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_floor;
    ce && tracking && level_reg >= floor_eff |=> level_reg >= $past(floor_eff);
  endproperty
  a_floor: assert property (p_floor) else $error("level under floor");

  property p_max;
    ce && tracking |=> level_reg <= $past(max_level);
  endproperty
  a_max: assert property (p_max) else $error("level over maximum");

  property p_no_reg;
    ce && !uv_s2_reg && !reg_enable |=> state_reg == alb_pkg::RS_IDLE ##1
      (!ce || level_reg == $past(max_level));
  endproperty
  a_no_reg: assert property (p_no_reg) else $error("sensor acted");

  property p_pause;
    ce && state_reg == alb_pkg::RS_PAUSE |=> $stable(level_reg);
  endproperty
  a_pause: assert property (p_pause) else $error("level moved in pause");

  // level follows the shut state, one edge after the flags
  property p_uv;
    ce && uv_s2_reg |=> shutdown && !main_string_en ##1
      (!ce || level_reg == 5'h00);
  endproperty
  a_uv: assert property (p_uv) else $error("no shutdown on uv");

  property p_main_first;
    $rose(|active) |-> $past(main_string_en);
  endproperty
  a_main_first: assert property (p_main_first) else $error("pwm first");

  property p_one_step;
    ce && tracking && level_reg <= max_level && level_reg >= floor_eff
      |=> (level_reg == $past(level_reg) ||
      level_reg == $past(level_reg) + 5'h01 ||
      level_reg == $past(level_reg) - 5'h01);
  endproperty
  a_one_step: assert property (p_one_step) else $error("multi step");

  property p_timing;
    ce && tracking && level_next != level_reg && level_reg <= max_level &&
      level_reg >= floor_eff |-> base_tick_reg &&
      step_cnt_reg == period - 7'h01;
  endproperty
  a_timing: assert property (p_timing) else $error("step off time");

  property p_bad_sel;
    ce && tracking && !sel_ok && level_reg <= max_level &&
      level_reg >= floor_eff |=> $stable(level_reg);
  endproperty
  a_bad_sel: assert property (p_bad_sel) else $error("stepped bad sel");

  property p_sync;
    is_sync |-> go[0] == go[1] && go[1] == go[2] && tgt[1] == tgt[0];
  endproperty
  a_sync: assert property (p_sync) else $error("sync mismatch");

  property p_stagger;
    seq == alb_pkg::SEQ_STAGGER && go[1] |-> done[0];
  endproperty
  a_stagger: assert property (p_stagger) else $error("early start");

  c_down: cover property (ce && step_fire && dir_dn);
  c_up: cover property (ce && step_fire && dir_up);
  c_uv: cover property ($rose(shutdown));
  c_stag: cover property (seq == alb_pkg::SEQ_STAGGER && $rose(go[2]));
endmodule : alb_ambient_ctrl
`default_nettype wire

/* File: tb/alb_photo_model.sv */
// photo sensor with its filter network, as seen at the sense pins
`timescale 1ns/10ps
`default_nettype none
module alb_photo_model (
  // clock
  input wire logic clk,
  // light falling on the sensor
  input wire logic [4:0] light,
  // filtered sensor code
  output logic [4:0] sense
);
  initial sense = 5'h00;
  // slew limit stands in for the rc filter, no instant jumps
  always @(posedge clk) begin
    if (sense < light)
      sense <= sense + 5'h01;
    else if (sense > light)
      sense <= sense - 5'h01;
  end
endmodule : alb_photo_model
`default_nettype wire

/* File: tb/tb_alb_ambient_ctrl.sv */
// testbench of the ambient brightness block
`timescale 1ns/10ps
`default_nettype none
module tb_alb_ambient_ctrl;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic busy = 1'b0;
  logic uv = 1'b0;
  logic [4:0] light = 5'h00;
  logic [1:0] mode = 2'h0;
  logic [2:0] en = 3'h0;
  logic [4:0] d0 = 5'h00;
  logic [4:0] d1 = 5'h00;
  logic [4:0] d2 = 5'h00;
  logic ce = 1'b1;
  logic [4:0] mx = 5'h14;
  logic [7:0] rdata;
  logic [4:0] sense;
  logic [4:0] led;
  logic men;
  logic [2:0] pwm;
  logic regl;
  logic shut;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [7:0] r;
  int c[3];
  int sy;
  logic [7:0] gt[5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10};
  logic [4:0] tl[5] = '{5'h02, 5'h04, 5'h08, 5'h10, 5'h14};

  always #2 clk = ~clk;

  alb_photo_model sensor (.clk(clk), .light(light), .sense(sense));

  // short base tick keeps the slow ramps inside the run
  alb_ambient_ctrl #(.STEP_BASE_CYCLES(4)) uut (
    .clk(clk), .rst(rst), .ce(ce),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .bus_cmd_busy(busy),
    .ambient_sense_input(sense), .undervoltage_detect(uv),
    .max_level(mx), .pwm_seq_mode(mode), .pwm_chan_en(en),
    .pwm_duty0(d0), .pwm_duty1(d1), .pwm_duty2(d2),
    .led_string_current(led), .main_string_en(men), .pwm_out(pwm),
    .regulating(regl), .shutdown(shut)
  );

  task automatic final_report();
    if (err_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [15:0] got,
                     input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %0h got %0h", nm, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
  endtask : wreg

  task automatic rreg(input logic [7:0] a);
    tick(1);
    addr = a;
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    tick(1);
    r = rdata;
  endtask : rreg

  task automatic wlvl(input logic [4:0] v, input int lim);
    int n;
    n = 0;
    while (led !== v && n < lim) begin
      tick(1);
      n++;
    end
    chk("led", 16'(led), 16'(v));
  endtask : wlvl

  // cycles between the first two level changes
  task automatic meas(input int exp);
    int n;
    logic [4:0] p;
    n = 0;
    for (int i = 0; i < 2; i++) begin
      p = led;
      n = 0;
      while (led === p && n < 4000) begin
        tick(1);
        n++;
      end
    end
    chk("step", 16'(n), 16'(exp));
  endtask : meas

  // one full phase period of pwm highs, plus cycles out of sync
  task automatic cnt();
    c = '{0, 0, 0};
    sy = 0;
    repeat (32) begin
      tick(1);
      for (int i = 0; i < 3; i++) begin
        c[i] += int'(pwm[i]);
      end
      sy += int'(pwm != {3{pwm[0]}});
    end
  endtask : cnt

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      final_report();
    end
  end

  initial begin
    tick(10);
    rst = 1'b0;
    for (int i = 8; i < 11; i++) begin
      rreg(8'(i));
      chk("rst", 16'(r), 16'h0000);
    end
    wreg(8'h08, 8'h7F);
    rreg(8'h08);
    chk("gain", 16'(r), 16'h001F);
    wreg(8'h09, 8'hF2);
    rreg(8'h09);
    chk("floor", 16'(r), 16'h0002);
    wreg(8'h0A, 8'hC1);
    rreg(8'h0A);
    chk("tim", 16'(r), 16'h0001);
    rreg(8'h0B);
    chk("unmap", 16'(r), 16'h0000);
    chk("idle", 16'({regl, led}), 16'h0014);
    chk("main", 16'(men), 16'h0001);
    // bias on, zero gain: sensor must not move the level
    wreg(8'h08, 8'h80);
    tick(60);
    chk("g0", 16'(led), 16'h0014);
    light = 5'h08;
    for (int i = 0; i < 5; i++) begin
      wreg(8'h08, 8'h80 | gt[i]);
      wlvl(tl[i], 600);
      chk("reg", 16'(regl), 16'h0001);
    end
    wreg(8'h08, 8'h84);
    for (int k = 0; k < 6; k++) begin
      wreg(8'h0A, 8'h01 << k);
      light = 5'h00;
      wlvl(5'h02, 20000);
      light = 5'h1F;
      meas(4 << k);
      wlvl(5'h14, 20000);
      light = 5'h00;
      meas(8 << k);
    end
    wlvl(5'h02, 20000);
    for (int i = 0; i < 2; i++) begin
      wreg(8'h0A, (i == 0) ? 8'h00 : 8'h03);
      light = 5'h1F;
      tick(100);
      chk("hold", 16'(led), 16'h0002);
      light = 5'h00;
    end
    // busy first, so no step slips in as the timing field turns valid
    busy = 1'b1;
    wreg(8'h0A, 8'h01);
    light = 5'h1F;
    tick(100);
    chk("busy", 16'(led), 16'h0002);
    ce = 1'b0;
    busy = 1'b0;
    tick(40);
    chk("ce", 16'(led), 16'h0002);
    ce = 1'b1;
    wlvl(5'h14, 300);
    mx = 5'h10;
    wlvl(5'h10, 10);
    uv = 1'b1;
    tick(6);
    chk("uv", 16'({shut, men, pwm, led}), 16'h0200);
    uv = 1'b0;
    tick(6);
    chk("uvoff", 16'({shut, men}), 16'h0001);
    mode = 2'h3;
    en = 3'b001;
    d0 = 5'h05;
    tick(4);
    cnt();
    chk("free", 16'(c[0] * 64 + c[1] + c[2]), 16'h0140);
    mode = 2'h0;
    d0 = 5'h06;
    tick(60);
    cnt();
    chk("sync", 16'(c[2] * 64 + sy), 16'h0180);
    en = 3'b000;
    tick(200);
    mode = 2'h1;
    en = 3'b111;
    d0 = 5'h0C;
    d1 = 5'h08;
    d2 = 5'h08;
    cnt();
    chk("stag", 16'(c[1] + c[2]), 16'h0000);
    tick(150);
    cnt();
    chk("stag2", 16'(c[2]), 16'h0008);
    mode = 2'h2;
    en = 3'b010;
    d1 = 5'h04;
    tick(80);
    cnt();
    chk("indep", 16'(c[0] * 64 + c[1] * 8 + c[2]), 16'h0020);
    final_report();
  end
endmodule : tb_alb_ambient_ctrl
`default_nettype wire
